/* File: rtl/hop_ctrl_pkg.sv */
/*
  Package for the receive channel hop and frequency control block: register
  offsets, field positions, reset values, command codes and timing counts.
  Assumes a 100 MHz system clock and a plain register port with 16-bit data.
*/
package hop_ctrl_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [7:0] OFS_RSSI_OFFSET = 8'h00; // rssi_offset_setting
  localparam logic [7:0] OFS_RSSI_LIMIT  = 8'h01; // rssi_limit_setting
  localparam logic [7:0] OFS_INTEGER     = 8'h02; // integer_part
  localparam logic [7:0] OFS_FRAC_HIGH   = 8'h03; // synth_fraction_high
  localparam logic [7:0] OFS_FRAC_MID    = 8'h04; // synth_fraction_mid
  localparam logic [7:0] OFS_FRAC_LOW    = 8'h05; // synth_fraction_low
  localparam logic [7:0] OFS_STEP_HIGH   = 8'h06;
  localparam logic [7:0] OFS_STEP_LOW    = 8'h07;
  localparam logic [7:0] OFS_HOP_CTRL    = 8'h08;
  localparam logic [7:0] OFS_TABLE_SIZE  = 8'h09;
  localparam logic [7:0] OFS_PIN_CFG     = 8'h0a;
  localparam logic [7:0] OFS_OSC_COUNT   = 8'h0b; // osc_calibration_count
  localparam logic [7:0] OFS_COMMAND     = 8'h0c;
  localparam logic [7:0] OFS_STATUS      = 8'h0d;
  localparam logic [7:0] OFS_RSSI_COMP   = 8'h0e;
  localparam logic [7:0] OFS_CHANNEL     = 8'h0f;
  localparam logic [1:0] TABLE_PAGE      = 2'b01; // 0x40..0x7f hold the hop table

  // hop control fields
  localparam int unsigned HC_RSSI_EN  = 0;
  localparam int unsigned HC_PRE_EN   = 1;
  localparam int unsigned HC_SYNC_EN  = 2;
  localparam int unsigned HC_AUTO_EN  = 3;
  localparam int unsigned HC_RAW_MODE = 4;

  // command fields and codes
  localparam int unsigned CMD_CHAN_GIVEN = 3;
  localparam int unsigned CMD_CHAN_LSB   = 8;
  localparam logic [2:0]  CMD_START_RX   = 3'h1;
  localparam logic [2:0]  CMD_START_TX   = 3'h2;
  localparam logic [2:0]  CMD_RX_HOP     = 3'h3;
  localparam logic [2:0]  CMD_IDLE       = 3'h4;

  // general-purpose pin routing codes, 3 bits per pin
  localparam int unsigned PIN_COUNT   = 4;
  localparam logic [2:0]  PIN_LOW     = 3'h0;
  localparam logic [2:0]  PIN_ABOVE   = 3'h1;
  localparam logic [2:0]  PIN_LATCHED = 3'h2;
  localparam logic [2:0]  PIN_HOP     = 3'h3;
  localparam logic [2:0]  PIN_WRAP    = 3'h4;

  // reset values and constants
  localparam logic [6:0]  RSSI_OFFSET_ZERO = 7'h32;
  localparam logic [7:0]  RSSI_LIMIT_RST   = 8'hff;
  localparam logic [7:0]  SKIP_ENTRY       = 8'hff;
  localparam int unsigned TABLE_DEPTH      = 64;
  localparam int unsigned FRAC_BITS        = 19;
  localparam int unsigned WORD_W           = 28;

  // timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned AUTO_HOP_TIME_US = 115;
  localparam int unsigned MAN_HOP_TIME_US  = 75;
  localparam int unsigned AUTO_HOP_CYC     = AUTO_HOP_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned MAN_HOP_CYC      = MAN_HOP_TIME_US * 1000 / CLK_PERIOD_NS;

  // controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX   = 4'b0010,
    ST_TX   = 4'b0100,
    ST_TUNE = 4'b1000
  } hop_state_t;

endpackage : hop_ctrl_pkg

/* File: rtl/rx_channel_hop_freq_control.sv */
/*
  Channel selection and automatic receive hopping control: RSSI offset and
  threshold flags, synthesizer word from base plus channel times step, hop
  table walk with skip entries, dwell/hop decision and retune timing.
  Assumes modem inputs synchronous to clk_sys_i and timeout/valid inputs
  given as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_channel_hop_freq_control
  import hop_ctrl_pkg::*;
#(
  parameter int unsigned AUTO_TURN_CYC = AUTO_HOP_CYC,
  parameter int unsigned MAN_TURN_CYC  = MAN_HOP_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // register port
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wr_data_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [DATA_W-1:0]    rd_data_o,
  // modem status
  input  wire logic [7:0]           rssi_raw_i,
  input  wire logic                 rssi_valid_i,
  input  wire logic                 preamble_timeout_i,
  input  wire logic                 sync_timeout_i,
  // synthesizer and radio control
  output logic      [WORD_W-1:0]    freq_word_o,
  output logic      [7:0]           osc_count_o,
  output logic                      osc_count_use_o,
  output logic                      rx_en_o,
  output logic                      tx_en_o,
  output logic                      tune_o,
  // rssi and pins
  output logic      [7:0]           rssi_comp_o,
  output logic      [PIN_COUNT-1:0] pin_o
);

  // settings
  logic [6:0]  rssi_offset_reg;
  logic [7:0]  rssi_limit_reg;
  logic [7:0]  integer_reg;
  logic [19:0] fraction_reg;
  logic [15:0] step_reg;
  logic [4:0]  hop_ctrl_reg;
  logic [6:0]  table_size_reg;
  logic [11:0] pin_cfg_reg;
  logic [7:0]  osc_count_reg;
  logic [7:0]  table_mem [TABLE_DEPTH];
  // state
  hop_state_t  state_reg;
  hop_state_t  after_tune_reg;
  logic [7:0]  chan_reg;
  logic [5:0]  idx_reg;
  logic [15:0] tune_cnt_reg;
  logic        scan_reg;
  logic [6:0]  scan_cnt_reg;
  logic        stay_reg;
  logic        above_reg;
  logic        latched_reg;
  logic        hop_tgl_reg;
  logic        wrap_tgl_reg;

  // decode helpers
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg
  logic       cmd_wr;
  logic [2:0] cmd_op;
  logic [7:0] cmd_chan;
  assign cmd_wr   = wr_i && is_reg(addr_i, OFS_COMMAND);
  assign cmd_op   = wr_data_i[2:0];
  assign cmd_chan = wr_data_i[CMD_CHAN_LSB +: 8];

  // rssi compensation in half-dB units, two units per offset step
  logic signed [10:0] comp_wide;
  logic [7:0]         comp_sat;
  logic               above_now;
  assign comp_wide = $signed({3'b000, rssi_raw_i}) + $signed({3'b000, rssi_offset_reg, 1'b0})
                   - $signed({3'b000, RSSI_OFFSET_ZERO, 1'b0});
  assign comp_sat  = comp_wide < 0 ? 8'h00 : (comp_wide > 11'sd255 ? 8'hff : comp_wide[7:0]);
  assign above_now = comp_sat > rssi_limit_reg;

  // hop decision: first enabled condition met decides
  logic raw_mode;
  logic hop_cond;
  logic stay_cond;
  logic hop_go;
  logic enter_rx;
  assign raw_mode  = hop_ctrl_reg[HC_RAW_MODE];
  assign stay_cond = hop_ctrl_reg[HC_RSSI_EN] && rssi_valid_i && above_now;
  assign hop_cond  = (hop_ctrl_reg[HC_RSSI_EN] && rssi_valid_i && !above_now)
                   || (!raw_mode && hop_ctrl_reg[HC_PRE_EN] && preamble_timeout_i)
                   || (!raw_mode && hop_ctrl_reg[HC_SYNC_EN] && sync_timeout_i);
  assign hop_go    = (state_reg == ST_RX) && hop_ctrl_reg[HC_AUTO_EN] && !stay_reg
                   && !stay_cond && hop_cond && (table_size_reg != 7'h00) && !cmd_wr;
  assign enter_rx  = (state_reg == ST_TUNE) && (tune_cnt_reg == 16'h0001) && !scan_reg
                   && (after_tune_reg == ST_RX) && !cmd_wr;

  // next table index, wrapping at the active size
  logic [5:0] idx_nxt;
  logic       idx_wrap;
  assign idx_wrap = ({1'b0, idx_reg} + 7'h01) >= table_size_reg;
  assign idx_nxt  = idx_wrap ? 6'h00 : idx_reg + 6'h01;
  // register writes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rssi_offset_reg <= RSSI_OFFSET_ZERO;
      rssi_limit_reg  <= RSSI_LIMIT_RST;
      integer_reg     <= 8'h00;
      fraction_reg    <= 20'h00000;
      step_reg        <= 16'h0000;
      hop_ctrl_reg    <= 5'h00;
      table_size_reg  <= 7'h00;
      pin_cfg_reg     <= 12'h000;
      osc_count_reg   <= 8'h00;
    end else if (wr_i) begin
      if (is_reg(addr_i, OFS_RSSI_OFFSET)) rssi_offset_reg <= wr_data_i[6:0];
      if (is_reg(addr_i, OFS_RSSI_LIMIT))  rssi_limit_reg  <= wr_data_i[7:0];
      if (is_reg(addr_i, OFS_INTEGER))     integer_reg     <= wr_data_i[7:0];
      if (is_reg(addr_i, OFS_FRAC_HIGH))   fraction_reg[19:16] <= wr_data_i[3:0];
      if (is_reg(addr_i, OFS_FRAC_MID))    fraction_reg[15:8]  <= wr_data_i[7:0];
      if (is_reg(addr_i, OFS_FRAC_LOW))    fraction_reg[7:0]   <= wr_data_i[7:0];
      if (is_reg(addr_i, OFS_STEP_HIGH))   step_reg[15:8]  <= wr_data_i[7:0];
      if (is_reg(addr_i, OFS_STEP_LOW))    step_reg[7:0]   <= wr_data_i[7:0];
      if (is_reg(addr_i, OFS_HOP_CTRL))    hop_ctrl_reg    <= wr_data_i[4:0];
      if (is_reg(addr_i, OFS_TABLE_SIZE))  begin
        table_size_reg <= (wr_data_i[7:0] > 8'd64) ? 7'd64 : wr_data_i[6:0];
      end
      if (is_reg(addr_i, OFS_PIN_CFG))     pin_cfg_reg     <= wr_data_i[11:0];
      if (is_reg(addr_i, OFS_OSC_COUNT))   osc_count_reg   <= wr_data_i[7:0];
    end
  end

  // hop table storage, no reset
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && addr_i[7:6] == TABLE_PAGE) begin
      table_mem[addr_i[5:0]] <= wr_data_i[7:0];
    end
  end
  // controller: commands, dwell, table walk and retune timing
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg      <= ST_IDLE;
      after_tune_reg <= ST_IDLE;
      chan_reg       <= 8'h00;
      idx_reg        <= 6'h00;
      tune_cnt_reg   <= 16'h0000;
      scan_reg       <= 1'b0;
      scan_cnt_reg   <= 7'h00;
      stay_reg       <= 1'b0;
      hop_tgl_reg    <= 1'b0;
      wrap_tgl_reg   <= 1'b0;
    end else if (cmd_wr) begin
      scan_reg <= 1'b0;
      unique case (cmd_op)
        CMD_START_RX, CMD_START_TX: begin
          if (wr_data_i[CMD_CHAN_GIVEN]) chan_reg <= cmd_chan;
          idx_reg        <= 6'h00;
          state_reg      <= ST_TUNE;
          after_tune_reg <= (cmd_op == CMD_START_RX) ? ST_RX : ST_TX;
          tune_cnt_reg   <= AUTO_TURN_CYC[15:0];
        end
        CMD_RX_HOP: begin
          chan_reg       <= cmd_chan;
          state_reg      <= ST_TUNE;
          after_tune_reg <= ST_RX;
          tune_cnt_reg   <= MAN_TURN_CYC[15:0];
        end
        CMD_IDLE: state_reg <= ST_IDLE;
        default: ;
      endcase
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_TX: ;
        ST_RX: begin
          if (stay_cond && hop_ctrl_reg[HC_AUTO_EN]) stay_reg <= 1'b1;
          if (hop_go) begin
            state_reg      <= ST_TUNE;
            after_tune_reg <= ST_RX;
            tune_cnt_reg   <= AUTO_TURN_CYC[15:0];
            scan_reg       <= 1'b1;
            scan_cnt_reg   <= 7'h00;
          end
        end
        ST_TUNE: begin
          if (scan_reg) begin
            idx_reg      <= idx_nxt;
            scan_cnt_reg <= scan_cnt_reg + 7'h01;
            if (idx_wrap) wrap_tgl_reg <= ~wrap_tgl_reg;
            if (table_mem[idx_nxt] != SKIP_ENTRY) begin
              chan_reg    <= table_mem[idx_nxt];
              scan_reg    <= 1'b0;
              hop_tgl_reg <= ~hop_tgl_reg;
            end else if (scan_cnt_reg + 7'h01 >= table_size_reg) begin
              scan_reg <= 1'b0;
            end
          end
          if (tune_cnt_reg > 16'h0001) begin
            tune_cnt_reg <= tune_cnt_reg - 16'h0001;
          end else if (!scan_reg) begin
            state_reg <= after_tune_reg;
            stay_reg  <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // live and latched threshold flags; a set in the entry cycle wins
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      above_reg   <= 1'b0;
      latched_reg <= 1'b0;
    end else begin
      above_reg   <= above_now && (state_reg == ST_RX);
      latched_reg <= (above_now && (state_reg == ST_RX)) || (latched_reg && !enter_rx);
    end
  end

  // synthesizer word: integer scaled by 2^19 plus fraction plus channel step
  logic [WORD_W-1:0] word_calc;
  assign word_calc = {1'b0, integer_reg, 19'h00000} + {8'h00, fraction_reg}
                   + {4'h0, 24'(chan_reg) * 24'(step_reg)};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      freq_word_o     <= '0;
      osc_count_o     <= 8'h00;
      osc_count_use_o <= 1'b0;
      rx_en_o         <= 1'b0;
      tx_en_o         <= 1'b0;
      tune_o          <= 1'b0;
      rssi_comp_o     <= 8'h00;
    end else begin
      freq_word_o <= word_calc;
      if (cmd_wr && cmd_op == CMD_RX_HOP) begin
        osc_count_o     <= osc_count_reg;
        osc_count_use_o <= 1'b1;
      end else if (cmd_wr || hop_go) begin
        osc_count_use_o <= 1'b0;
      end
      rx_en_o     <= (state_reg == ST_RX);
      tx_en_o     <= (state_reg == ST_TX);
      tune_o      <= (state_reg == ST_TUNE);
      rssi_comp_o <= comp_sat;
    end
  end

  // pin routing, one selector per pin; sources passed in so the assign sees them change
  function automatic logic pin_route(input logic [2:0] sel, input logic [3:0] src);
    unique case (sel)
      PIN_ABOVE:   pin_route = src[0];
      PIN_LATCHED: pin_route = src[1];
      PIN_HOP:     pin_route = src[2];
      PIN_WRAP:    pin_route = src[3];
      default:     pin_route = 1'b0;
    endcase
  endfunction : pin_route
  logic [PIN_COUNT-1:0] pin_next;
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    assign pin_next[p] = pin_route(pin_cfg_reg[3*p +: 3],
                                   {wrap_tgl_reg, hop_tgl_reg, latched_reg, above_reg});
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) pin_o <= '0;
    else pin_o <= pin_next;
  end

  // register reads, data in the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (rd_i) begin
      if (addr_i[7:6] == TABLE_PAGE) rd_data_o <= {8'h00, table_mem[addr_i[5:0]]};
      else begin
        unique case (addr_i)
          OFS_RSSI_OFFSET: rd_data_o <= {9'h000, rssi_offset_reg};
          OFS_RSSI_LIMIT:  rd_data_o <= {8'h00, rssi_limit_reg};
          OFS_INTEGER:     rd_data_o <= {8'h00, integer_reg};
          OFS_FRAC_HIGH:   rd_data_o <= {12'h000, fraction_reg[19:16]};
          OFS_FRAC_MID:    rd_data_o <= {8'h00, fraction_reg[15:8]};
          OFS_FRAC_LOW:    rd_data_o <= {8'h00, fraction_reg[7:0]};
          OFS_STEP_HIGH:   rd_data_o <= {8'h00, step_reg[15:8]};
          OFS_STEP_LOW:    rd_data_o <= {8'h00, step_reg[7:0]};
          OFS_HOP_CTRL:    rd_data_o <= {11'h000, hop_ctrl_reg};
          OFS_TABLE_SIZE:  rd_data_o <= {9'h000, table_size_reg};
          OFS_PIN_CFG:     rd_data_o <= {4'h0, pin_cfg_reg};
          OFS_OSC_COUNT:   rd_data_o <= {8'h00, osc_count_reg};
          OFS_STATUS:      rd_data_o <= {2'b00, idx_reg, stay_reg, scan_reg, latched_reg,
                                         above_reg, state_reg};
          OFS_RSSI_COMP:   rd_data_o <= {8'h00, rssi_comp_o};
          OFS_CHANNEL:     rd_data_o <= {8'h00, chan_reg};
          default:         rd_data_o <= '0;
        endcase
      end
    end else begin
      rd_data_o <= '0;
    end
  end

  // checks, with a cycle counter for the long retune window
  logic [15:0] tune_age;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) tune_age <= 16'h0000;
    else tune_age <= (state_reg == ST_TUNE) ? tune_age + 16'h0001 : 16'h0000;
  end
  sequence s_auto_hop_start;
    hop_go;
  endsequence
  sequence s_scan_found;
    scan_reg && (state_reg == ST_TUNE) && !cmd_wr && table_mem[idx_nxt] != SKIP_ENTRY;
  endsequence
  a_offset_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rssi_offset_reg == RSSI_OFFSET_ZERO |=> rssi_comp_o == $past(rssi_raw_i))
    else $error("rssi changed with zero offset code");
  a_hop_turnaround: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tune_age <= AUTO_TURN_CYC[15:0])
    else $error("retune lasted longer than the automatic hop time");
  a_hop_enters_tune: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_auto_hop_start |=> (state_reg == ST_TUNE) && scan_reg ##1 tune_o)
    else $error("hop decision did not start a retune");
  a_skip_found: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_scan_found |=> !scan_reg && chan_reg != SKIP_ENTRY && hop_tgl_reg != $past(hop_tgl_reg))
    else $error("skip entry taken or hop toggle missed");
  a_wrap_base: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    scan_reg && (state_reg == ST_TUNE) && !cmd_wr && idx_wrap |=> idx_reg == 6'h00)
    else $error("table walk did not wrap to the base entry");
  a_chan_kept: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cmd_wr && cmd_op == CMD_START_RX && !wr_data_i[CMD_CHAN_GIVEN] |=> $stable(chan_reg))
    else $error("channel changed without a channel argument");
  a_freq_word: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $stable(chan_reg) && $stable(step_reg) && $stable(integer_reg) && $stable(fraction_reg)
    |-> freq_word_o == (28'(integer_reg) << 19) + 28'(fraction_reg)
                       + 28'(chan_reg) * 28'(step_reg))
    else $error("synthesizer word does not follow base plus channel step");
  a_raw_no_timeout: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    raw_mode && !hop_ctrl_reg[HC_RSSI_EN] |-> !hop_go)
    else $error("raw mode hopped on a packet timeout");
  a_stay_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_RX) && stay_reg && !cmd_wr |=> (state_reg == ST_RX) && $stable(chan_reg))
    else $error("hopped after deciding to stay");

endmodule : rx_channel_hop_freq_control
`default_nettype wire

/* File: verif/host_model.sv */
/*
  host model: drives the register port of the hop block.
  assumes one task call at a time, clocked by clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
  import hop_ctrl_pkg::*;
(
  // clock
  input  wire logic              clk_sys_i,
  // register port
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wr_data_o,
  output logic                   wr_o,
  output logic                   rd_o,
  input  wire logic [DATA_W-1:0] rd_data_i
);
  // bus idle before the first request
  initial begin
    addr_o = 8'h00;
    wr_data_o = 16'h0000;
    {wr_o, rd_o} = 2'b00;
  end
  // one-cycle write, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    wr_data_o <= ~d;
  endtask : wr
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    @(posedge clk_sys_i);
    d = rd_data_i;
  endtask : rd
  // command word: channel, channel-given flag, opcode
  task automatic cmd(input logic [2:0] op, input logic g, input logic [7:0] ch);
    wr(OFS_COMMAND, {ch, 4'h0, g, op});
  endtask : cmd
endmodule : host_model
`default_nettype wire

/* File: verif/tb.sv */
/*
  tb: self-checking bench for the hop block with an integer model.
  assumes short turnaround parameters and the host model file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hop_ctrl_pkg::*;
  localparam int AT = 20;
  localparam int MT = 10;
  logic clk_sys_i, rst_i, wr_i, rd_i, rssi_valid_i, preamble_timeout_i, sync_timeout_i;
  logic [7:0] addr_i, rssi_raw_i, osc_count_o, rssi_comp_o;
  logic [15:0] wr_data_i, rd_data_o, d;
  logic [27:0] freq_word_o;
  logic osc_count_use_o, rx_en_o, tx_en_o, tune_o;
  logic [3:0] pin_o;
  int num_errors = 0, comparisons = 0, seed = 96675, cyc = 0;
  int tbl[$], size, idx, chan, hop_t, wrap_t, lat, integ, frac, step, off, r, c, oc;
  // device under test and host
  rx_channel_hop_freq_control #(.AUTO_TURN_CYC(AT), .MAN_TURN_CYC(MT))
    rx_channel_hop_freq_control_i (.clk_sys_i, .rst_i, .addr_i, .wr_data_i, .wr_i,
    .rd_i, .rd_data_o, .rssi_raw_i, .rssi_valid_i, .preamble_timeout_i,
    .sync_timeout_i, .freq_word_o, .osc_count_o, .osc_count_use_o, .rx_en_o,
    .tx_en_o, .tune_o, .rssi_comp_o, .pin_o);
  host_model host_model_i (.clk_sys_i, .addr_o(addr_i), .wr_data_o(wr_data_i),
    .wr_o(wr_i), .rd_o(rd_i), .rd_data_i(rd_data_o));
  // clock and hang guard
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle pulse on rssi valid (0), preamble (1) or sync (2) timeout
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    {sync_timeout_i, preamble_timeout_i, rssi_valid_i} <= 3'b001 << k;
    @(posedge clk_sys_i);
    {sync_timeout_i, preamble_timeout_i, rssi_valid_i} <= 3'b000;
  endtask : pulse
  // length of the tune phase in cycles
  task automatic retune(input int t);
    int n;
    n = 0;
    while (tune_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys_i);
      n++;
    end
    n = 0;
    while (tune_o === 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(n, t);
  endtask : retune
  // radio state, synthesizer word and channel after a retune
  task automatic check_rx(input logic tx);
    logic [15:0] v;
    @(posedge clk_sys_i);
    chk(rx_en_o, !tx);
    chk(tx_en_o, tx);
    chk(freq_word_o, ((integ << 19) + frac + chan * step) & 28'hfffffff);
    host_model_i.rd(OFS_CHANNEL, v);
    chk(v, chan);
  endtask : check_rx
  // next table entry: in order, wrap at size, skip all-ones
  task automatic hop_model();
    do begin
      idx = (idx + 1) % size;
      if (idx == 0) wrap_t++;
    end while (tbl[idx] == 255);
    hop_t++;
    chan = tbl[idx];
  endtask : hop_model
  // main sequence
  initial begin
    clk_sys_i = 1'b0;
    rst_i = 1'b1;
    rssi_raw_i = 8'h00;
    {rssi_valid_i, preamble_timeout_i, sync_timeout_i} = 3'b000;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    host_model_i.rd(OFS_RSSI_OFFSET, d);
    chk(d, 16'h0032);
    host_model_i.rd(8'h20, d);
    chk(d, 16'h0000);
    host_model_i.rd(OFS_CHANNEL, d);
    chk(d, 16'h0000);
    $display("test reset done");
    integ = $random(seed) & 127;
    frac = 32'h80000 | ($random(seed) & 32'h7ffff);
    step = $random(seed) & 32'hffff;
    tbl = {3, 255, 7, 9, 17};
    size = 4;
    host_model_i.wr(OFS_INTEGER, integ[15:0]);
    host_model_i.wr(OFS_FRAC_HIGH, 16'(frac >> 16));
    host_model_i.wr(OFS_FRAC_MID, 16'((frac >> 8) & 255));
    host_model_i.wr(OFS_FRAC_LOW, 16'(frac & 255));
    host_model_i.wr(OFS_STEP_HIGH, 16'(step >> 8));
    host_model_i.wr(OFS_STEP_LOW, 16'(step & 255));
    for (int i = 0; i < 5; i++) host_model_i.wr(8'h40 + 8'(i), 16'(tbl[i]));
    host_model_i.wr(OFS_TABLE_SIZE, 16'(size));
    host_model_i.wr(OFS_PIN_CFG, 16'h08d1);
    host_model_i.wr(OFS_RSSI_LIMIT, 16'h0080);
    host_model_i.wr(OFS_HOP_CTRL, 16'h0009);
    host_model_i.cmd(CMD_START_RX, 1'b1, 8'd3);
    {idx, chan} = {32'd0, 32'd3};
    retune(AT);
    check_rx(1'b0);
    for (int i = 0; i < 6; i++) begin
      off = 40 + ($random(seed) & 15);
      r = $random(seed) & 255;
      host_model_i.wr(OFS_RSSI_OFFSET, 16'(off));
      rssi_raw_i <= 8'(r);
      repeat (4) @(posedge clk_sys_i);
      c = r + 2 * (off - 50);
      c = (c < 0) ? 0 : (c > 255) ? 255 : c;
      lat = lat | (c > 128);
      chk(rssi_comp_o, c);
      chk(pin_o[0], c > 128);
      chk(pin_o[1], lat);
    end
    $display("test rssi done");
    host_model_i.wr(OFS_RSSI_OFFSET, 16'h0032);
    rssi_raw_i <= 8'h10;
    for (int i = 0; i < 5; i++) begin
      pulse(0);
      hop_model();
      retune(AT);
      check_rx(1'b0);
      chk(pin_o[3:2], {wrap_t[0], hop_t[0]});
    end
    rssi_raw_i <= 8'hf0;
    pulse(0);
    repeat (30) @(posedge clk_sys_i);
    check_rx(1'b0);
    $display("test auto hop done");
    host_model_i.wr(OFS_HOP_CTRL, 16'h000e);
    host_model_i.cmd(CMD_START_RX, 1'b1, 8'd3);
    {idx, chan} = {32'd0, 32'd3};
    retune(AT);
    rssi_raw_i <= 8'h10;
    for (int k = 1; k < 3; k++) begin
      pulse(k);
      hop_model();
      retune(AT);
      check_rx(1'b0);
    end
    host_model_i.wr(OFS_HOP_CTRL, 16'h001e);
    pulse(0);
    pulse(1);
    repeat (30) @(posedge clk_sys_i);
    check_rx(1'b0);
    $display("test timeouts done");
    oc = $random(seed) & 255;
    host_model_i.wr(OFS_OSC_COUNT, 16'(oc));
    host_model_i.cmd(CMD_RX_HOP, 1'b1, 8'h21);
    chan = 33;
    retune(MT);
    check_rx(1'b0);
    chk({osc_count_use_o, osc_count_o}, 9'h100 | oc);
    host_model_i.cmd(CMD_START_RX, 1'b0, 8'h05);
    retune(AT);
    check_rx(1'b0);
    host_model_i.cmd(CMD_START_TX, 1'b1, 8'h05);
    chan = 5;
    retune(AT);
    check_rx(1'b1);
    $display("test commands done");
    host_model_i.cmd(CMD_IDLE, 1'b0, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    chk({rx_en_o, tx_en_o, tune_o}, 3'b000);
    host_model_i.rd(OFS_STATUS, d);
    chk(d, 16'h0001);
    host_model_i.rd(8'h42, d);
    chk(d, 16'(tbl[2]));
    $display("test idle done");
    results();
  end
endmodule : tb
`default_nettype wire
